// File: verilog/pci_ctl_pkg.sv
// Purpose: Shared constants and carrier types for the PCI-side control block
// Assumes: One PCI clock domain, asynchronous active-low reset
// Notes:   Error status and event bundles travel as packed structs
package pci_ctl_pkg;

  // ------------------------------------------------------------
  // Bus timing and command codes
  // ------------------------------------------------------------
  localparam int unsigned DEVSEL_WAIT_CYCLES = 5;
  localparam logic [2:0]  DEVSEL_WAIT_MAX    = 3'h5;
  localparam logic [2:0]  DEVSEL_WAIT_ZERO   = 3'h0;
  localparam int unsigned REQ_REL_MIN_CYCLES = 2;
  localparam int unsigned NUM_REQ            = 4;
  localparam logic [3:0]  CMD_CFG_READ       = 4'hA;
  localparam logic [3:0]  CMD_CFG_WRITE      = 4'hB;
  localparam logic [1:0]  CFG_TYPE0          = 2'h0;
  localparam logic [1:0]  REQ_CNT_ZERO       = 2'h0;
  localparam logic [1:0]  REQ_CNT_MIN        = 2'h2;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic addr_par;
    logic posted_data_par;
    logic posted_master_abort;
    logic posted_target_abort;
    logic posted_discard;
    logic delayed_write_discard;
    logic delayed_read_discard;
    logic delayed_timeout;
    logic express_aer;
  } sys_err_t;

  typedef struct packed {
    logic     data_par_err;
    logic     master_abort;
    logic     target_stop;
    logic     req_spacing_err;
    sys_err_t sys_err;
  } err_status_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_WAIT = 4'h2,
    M_DATA = 4'h4,
    M_END  = 4'h8
  } mst_state_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'h1,
    T_ACT  = 3'h2,
    T_REL  = 3'h4
  } tgt_state_t;

  function automatic logic even_par_ok(input logic [31:0] ad, input logic [3:0] cbe,
                                       input logic par);
    even_par_ok = ~(^{ad, cbe, par});
  endfunction

endpackage

// File: verilog/pci_side_ctl.sv
// Purpose: PCI-side transaction control and error signalling of a bridge
// Assumes: All pins synchronous to clk; two-way pins split into in/out/oe
// Notes:   Datapath, arbiter grants and parity generation are elsewhere
//
// What this block does
// - Targets assert DEVSEL to accept; as master, abort without DEVSEL in 5 cycles.
// - Drive DEVSEL, STOP, PERR inactive for one cycle before releasing them.
// - Locked transactions going upstream are not supported nor passed as locked.
// - Claim Type 0 configuration access only while IDSEL is high in address phase.
// - Assert PERR on data parity error in data received from the PCI bus.
// - SERR is shared wired-low; pull it only when system-error reporting enabled.
// - SERR on address parity error or posted-write data parity error.
// - SERR on posted write master abort, target abort or discard.
// - SERR on delayed request discard or delayed transaction master timeout.
// - In transparent mode, SERR also for advanced error reports from Express port.
// - Initiator drives FRAME low for the access, releases it on final data phase.
// - Parity is even over AD, CBE and PAR; mismatches are reported errors.
`timescale 1ns/100ps
`default_nettype none
module pci_side_ctl
  import pci_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Bus control inputs
  input  wire logic              frame_n_in,
  input  wire logic              irdy_n_in,
  input  wire logic              trdy_n_in,
  input  wire logic              devsel_n_in,
  input  wire logic              stop_n_in,
  input  wire logic              lock_n_in,
  input  wire logic              idsel,
  input  wire logic [31:0]       ad_in,
  input  wire logic [3:0]        cbe_n_in,
  input  wire logic              par_in,
  input  wire logic              perr_n_in,
  input  wire logic [NUM_REQ-1:0] req_n,
  // Internal control from the bridge core
  input  wire logic              mst_start,
  input  wire logic              mst_last,
  input  wire logic              tgt_claim,
  input  wire logic              tgt_stop,
  input  wire logic              tgt_done,
  input  wire logic              rx_data_phase,
  input  wire logic              serr_enable,
  input  wire logic              parity_resp_en,
  input  wire logic              transparent_mode,
  input  wire sys_err_t          sys_err_evt,
  input  wire logic              status_clear,
  // Driven pins
  output logic                   frame_n_out,
  output logic                   frame_oe,
  output logic                   devsel_n_out,
  output logic                   devsel_oe,
  output logic                   stop_n_out,
  output logic                   stop_oe,
  output logic                   perr_n_out,
  output logic                   perr_oe,
  output logic                   serr_n_out,
  output logic                   serr_oe,
  // Status to the bridge core
  output logic                   cfg_claim,
  output logic                   mst_abort,
  output logic                   mst_terminated,
  output logic                   upstream_locked,
  output err_status_t            err_status
);

  // ------------------------------------------------------------
  // Master side: FRAME and DEVSEL timeout
  // ------------------------------------------------------------
  mst_state_t m_state_reg, m_state_next;
  logic [2:0] dev_cnt_reg, dev_cnt_next;
  logic       frame_n_reg, frame_n_next, frame_oe_reg, frame_oe_next;
  logic       abort_reg, abort_next, term_reg, term_next;

  always_comb begin
    m_state_next = m_state_reg;
    dev_cnt_next = dev_cnt_reg;
    frame_n_next = frame_n_reg;
    frame_oe_next = frame_oe_reg;
    abort_next   = 1'b0;
    term_next    = 1'b0;
    unique case (m_state_reg)
      M_IDLE: begin
        frame_oe_next = 1'b0;
        frame_n_next  = 1'b1;
        if (mst_start) begin
          frame_n_next  = 1'b0;
          frame_oe_next = 1'b1;
          dev_cnt_next  = DEVSEL_WAIT_ZERO;
          m_state_next  = M_WAIT;
        end
      end
      M_WAIT: begin
        dev_cnt_next = dev_cnt_reg + 3'h1;
        if (!devsel_n_in) begin
          m_state_next = M_DATA;
        end else if (dev_cnt_reg == DEVSEL_WAIT_MAX - 3'h1) begin
          abort_next   = 1'b1;
          frame_n_next = 1'b1;
          m_state_next = M_END;
        end
      end
      M_DATA: begin
        if (!stop_n_in) begin
          term_next    = 1'b1;
          frame_n_next = 1'b1;
          m_state_next = M_END;
        end else if (mst_last) begin
          frame_n_next = 1'b1;
          m_state_next = M_END;
        end
      end
      M_END: begin
        frame_n_next  = 1'b1;
        frame_oe_next = 1'b0;
        m_state_next  = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m_state_reg  <= M_IDLE;
      dev_cnt_reg  <= DEVSEL_WAIT_ZERO;
      frame_n_reg  <= 1'b1;
      frame_oe_reg <= 1'b0;
      abort_reg    <= 1'b0;
      term_reg     <= 1'b0;
    end else begin
      m_state_reg  <= m_state_next;
      dev_cnt_reg  <= dev_cnt_next;
      frame_n_reg  <= frame_n_next;
      frame_oe_reg <= frame_oe_next;
      abort_reg    <= abort_next;
      term_reg     <= term_next;
    end
  end

  // ------------------------------------------------------------
  // Target side: DEVSEL and STOP with release cycle
  // ------------------------------------------------------------
  tgt_state_t t_state_reg, t_state_next;
  logic devsel_n_reg, devsel_n_next, devsel_oe_reg, devsel_oe_next;
  logic stop_n_reg, stop_n_next, stop_oe_reg, stop_oe_next;
  logic cfg_claim_reg, cfg_claim_next, lock_reg, lock_next;
  logic frame_d_reg;
  logic addr_phase;

  assign addr_phase = frame_d_reg & ~frame_n_in;

  always_comb begin
    t_state_next   = t_state_reg;
    devsel_n_next  = 1'b1;
    devsel_oe_next = 1'b0;
    stop_n_next    = 1'b1;
    stop_oe_next   = 1'b0;
    cfg_claim_next = 1'b0;
    lock_next      = 1'b0;
    unique case (t_state_reg)
      T_IDLE: begin
        if (addr_phase) begin
          cfg_claim_next = idsel && (ad_in[1:0] == CFG_TYPE0) &&
                           ((~cbe_n_in == CMD_CFG_READ) || (~cbe_n_in == CMD_CFG_WRITE));
          if (cfg_claim_next || tgt_claim) begin
            devsel_n_next  = 1'b0;
            devsel_oe_next = 1'b1;
            stop_oe_next   = 1'b1;
            t_state_next   = T_ACT;
          end
        end
      end
      T_ACT: begin
        devsel_n_next  = 1'b0;
        devsel_oe_next = 1'b1;
        stop_oe_next   = 1'b1;
        stop_n_next    = ~tgt_stop;
        lock_next      = 1'b0;
        if (tgt_done) begin
          devsel_n_next = 1'b1;
          stop_n_next   = 1'b1;
          t_state_next  = T_REL;
        end
      end
      T_REL: begin
        t_state_next = T_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_state_reg   <= T_IDLE;
      devsel_n_reg  <= 1'b1;
      devsel_oe_reg <= 1'b0;
      stop_n_reg    <= 1'b1;
      stop_oe_reg   <= 1'b0;
      cfg_claim_reg <= 1'b0;
      lock_reg      <= 1'b0;
      frame_d_reg   <= 1'b1;
    end else begin
      t_state_reg   <= t_state_next;
      devsel_n_reg  <= devsel_n_next;
      devsel_oe_reg <= devsel_oe_next;
      stop_n_reg    <= stop_n_next;
      stop_oe_reg   <= stop_oe_next;
      cfg_claim_reg <= cfg_claim_next;
      lock_reg      <= lock_next;
      frame_d_reg   <= frame_n_in;
    end
  end

  // ------------------------------------------------------------
  // Parity checking, PERR and SERR
  // ------------------------------------------------------------
  logic perr_n_reg, perr_n_next, perr_oe_reg, perr_oe_next;
  logic serr_n_reg, serr_n_next, serr_oe_reg, serr_oe_next;
  logic addr_chk_reg, addr_chk_next, data_chk_reg, data_chk_next;
  logic [31:0] ad_d_reg;
  logic [3:0]  cbe_d_reg;
  logic        data_bad, addr_bad, sys_any;
  sys_err_t    sys_now;

  always_comb begin
    addr_chk_next = addr_phase;
    data_chk_next = rx_data_phase & ~irdy_n_in & ~trdy_n_in;
    data_bad = data_chk_reg & ~even_par_ok(ad_d_reg, cbe_d_reg, par_in);
    addr_bad = addr_chk_reg & ~even_par_ok(ad_d_reg, cbe_d_reg, par_in);
    sys_now  = sys_err_evt;
    sys_now.addr_par = sys_err_evt.addr_par | addr_bad;
    sys_now.express_aer = sys_err_evt.express_aer & transparent_mode;
    sys_any = |sys_now;
    perr_n_next    = ~(data_bad & parity_resp_en);
    perr_oe_next   = ~perr_n_next | ~perr_n_reg;
    serr_n_next  = ~(sys_any & serr_enable);
    serr_oe_next = ~serr_n_next;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      perr_n_reg    <= 1'b1;
      perr_oe_reg   <= 1'b0;
      serr_n_reg    <= 1'b1;
      serr_oe_reg   <= 1'b0;
      addr_chk_reg  <= 1'b0;
      data_chk_reg  <= 1'b0;
      ad_d_reg      <= 32'h0000_0000;
      cbe_d_reg     <= 4'hF;
    end else begin
      perr_n_reg    <= perr_n_next;
      perr_oe_reg   <= perr_oe_next;
      serr_n_reg    <= serr_n_next;
      serr_oe_reg   <= serr_oe_next;
      addr_chk_reg  <= addr_chk_next;
      data_chk_reg  <= data_chk_next;
      ad_d_reg      <= ad_in;
      cbe_d_reg     <= cbe_n_in;
    end
  end

  // ------------------------------------------------------------
  // Request spacing watch and sticky status
  // ------------------------------------------------------------
  logic [1:0]      rel_cnt_reg  [NUM_REQ];
  logic [1:0]      rel_cnt_next [NUM_REQ];
  logic [NUM_REQ-1:0] req_d_reg, spacing_bad;
  err_status_t     stat_reg, stat_next;

  genvar g;
  generate
    for (g = 0; g < NUM_REQ; g++) begin : g_req
      always_comb begin
        rel_cnt_next[g] = rel_cnt_reg[g];
        spacing_bad[g]  = 1'b0;
        if (req_n[g] && !req_d_reg[g]) begin
          rel_cnt_next[g] = 2'h1;
        end else if (req_n[g] && rel_cnt_reg[g] != REQ_CNT_MIN &&
                     rel_cnt_reg[g] != REQ_CNT_ZERO) begin
          rel_cnt_next[g] = rel_cnt_reg[g] + 2'h1;
        end else if (!req_n[g]) begin
          spacing_bad[g]  = req_d_reg[g] && (rel_cnt_reg[g] == 2'h1);
          rel_cnt_next[g] = REQ_CNT_ZERO;
        end
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          rel_cnt_reg[g] <= REQ_CNT_ZERO;
          req_d_reg[g]   <= 1'b1;
        end else begin
          rel_cnt_reg[g] <= rel_cnt_next[g];
          req_d_reg[g]   <= req_n[g];
        end
      end
    end
  endgenerate

  always_comb begin
    stat_next = status_clear ? '0 : stat_reg;
    stat_next.data_par_err    = stat_next.data_par_err | data_bad | ~perr_n_in;
    stat_next.master_abort    = stat_next.master_abort | abort_reg;
    stat_next.target_stop     = stat_next.target_stop | term_reg;
    stat_next.req_spacing_err = stat_next.req_spacing_err | (|spacing_bad);
    stat_next.sys_err         = stat_next.sys_err | sys_now;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign frame_n_out     = frame_n_reg;
  assign frame_oe        = frame_oe_reg;
  assign devsel_n_out    = devsel_n_reg;
  assign devsel_oe       = devsel_oe_reg;
  assign stop_n_out      = stop_n_reg;
  assign stop_oe         = stop_oe_reg;
  assign perr_n_out      = perr_n_reg;
  assign perr_oe         = perr_oe_reg;
  assign serr_n_out      = serr_n_reg;
  assign serr_oe         = serr_oe_reg;
  assign cfg_claim       = cfg_claim_reg;
  assign mst_abort       = abort_reg;
  assign mst_terminated  = term_reg;
  assign upstream_locked = lock_reg;
  assign err_status      = stat_reg;

endmodule
`default_nettype wire

// File: verif/pci_side_ctl_monitor.sv
// Purpose: Concurrent checks on the PCI-side control pins
// Assumes: One clock domain, rstn asynchronous active low
// Notes:   Bound into every pci_side_ctl instance
`timescale 1ns/100ps
`default_nettype none
module pci_side_ctl_monitor
  import pci_ctl_pkg::*;
(
  // Clock, reset and inputs
  input wire logic     clk,
  input wire logic     rstn,
  input wire logic     frame_n_in,
  input wire logic     stop_n_in,
  input wire logic     idsel,
  input wire logic     rx_data_phase,
  input wire logic     serr_enable,
  input wire logic     transparent_mode,
  input wire sys_err_t sys_err_evt,
  // Design outputs
  input wire logic     frame_n_out,
  input wire logic     frame_oe,
  input wire logic     devsel_n_out,
  input wire logic     devsel_oe,
  input wire logic     stop_n_out,
  input wire logic     stop_oe,
  input wire logic     perr_n_out,
  input wire logic     perr_oe,
  input wire logic     serr_n_out,
  input wire logic     serr_oe,
  input wire logic     cfg_claim,
  input wire logic     mst_abort,
  input wire logic     mst_terminated,
  input wire logic     upstream_locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_abort_frame: assert property (mst_abort |-> frame_n_out && frame_oe ##1 !frame_oe)
    else $error("abort without frame release");
  a_stop_end: assert property (mst_terminated |-> $past(!stop_n_in) && frame_n_out)
    else $error("terminate without stop");
  a_devsel_rel: assert property ($fell(devsel_oe) |-> $past(devsel_n_out))
    else $error("devsel released while low");
  a_stop_rel: assert property ($fell(stop_oe) |-> $past(stop_n_out))
    else $error("stop released while low");
  a_perr_rel: assert property ($fell(perr_oe) |-> $past(perr_n_out))
    else $error("perr released while low");
  a_no_lock: assert property (upstream_locked == 1'b0)
    else $error("lock forwarded upstream");
  a_cfg_idsel: assert property (cfg_claim |-> $past(idsel) && $past(!frame_n_in))
    else $error("config claim without select");
  a_perr_cause: assert property (perr_oe && !perr_n_out |-> $past(rx_data_phase, 2))
    else $error("perr without received data");
  a_serr_gate: assert property (!serr_n_out |-> serr_oe && $past(serr_enable))
    else $error("serr pulled while disabled");
  a_serr_cause: assert property ($past(rstn && serr_enable && ((|sys_err_evt[8:1]) ||
    (sys_err_evt[0] && transparent_mode))) |-> serr_oe && !serr_n_out)
    else $error("serr missing after event");
endmodule
bind pci_side_ctl pci_side_ctl_monitor u_mon (.clk, .rstn, .frame_n_in, .stop_n_in, .idsel,
  .rx_data_phase, .serr_enable, .transparent_mode, .sys_err_evt, .frame_n_out, .frame_oe,
  .devsel_n_out, .devsel_oe, .stop_n_out, .stop_oe, .perr_n_out, .perr_oe, .serr_n_out,
  .serr_oe, .cfg_claim, .mst_abort, .mst_terminated, .upstream_locked);
`default_nettype wire

// File: verif/pci_tgt_model.sv
// Purpose: Far-side PCI target answering the bridge as master
// Assumes: Lines are pulled up when released
// Notes:   respond low models an absent target
`timescale 1ns/100ps
`default_nettype none
module pci_tgt_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Bus and control
  input  wire logic frame_n,
  input  wire logic respond,
  input  wire logic stop_req,
  output var  logic devsel_n,
  output var  logic stop_n
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      devsel_n <= 1'b1;
      stop_n   <= 1'b1;
    end else begin
      devsel_n <= !(respond && !frame_n);
      stop_n   <= !(respond && stop_req && !frame_n);
    end
  end
endmodule
`default_nettype wire

// File: verif/pci_side_control_and_error_signalling_tb_top.sv
// Purpose: Self-checking bench for the PCI-side control block
// Assumes: 125 MHz clock, pulled-up shared lines
// Notes:   Expected status kept in a bench-side model
`timescale 1ns/100ps
`default_nettype none
module pci_side_control_and_error_signalling_tb_top
  import pci_ctl_pkg::*;
;
  logic clk, rstn, irdy_n_in, trdy_n_in, lock_n_in, idsel, par_in, par_bad, mst_start, mst_last;
  logic tgt_claim, tgt_stop, tgt_done, rx_data_phase, serr_enable, parity_resp_en;
  logic transparent_mode, status_clear, bus_frame_n, respond, stop_req, clr;
  logic pd_devsel_n, pd_stop_n, frame_n_in, devsel_n_in, stop_n_in, perr_n_in;
  logic frame_n_out, frame_oe, devsel_n_out, devsel_oe, stop_n_out, stop_oe;
  logic perr_n_out, perr_oe, serr_n_out, serr_oe, cfg_claim, mst_abort;
  logic mst_terminated, upstream_locked;
  logic [31:0] ad_in;
  logic [3:0] cbe_n_in, req_n;
  logic [4:0] seen;
  logic [15:0] lf;
  sys_err_t sys_err_evt;
  err_status_t err_status, exp_st;
  int failures, n_tests;
  // Wired levels of the shared lines
  assign frame_n_in = frame_oe ? frame_n_out : bus_frame_n;
  assign devsel_n_in = devsel_oe ? devsel_n_out : pd_devsel_n;
  assign stop_n_in = stop_oe ? stop_n_out : pd_stop_n;
  assign perr_n_in = perr_oe ? perr_n_out : 1'b1;
  pci_side_ctl u_dut (.clk, .rstn, .frame_n_in, .irdy_n_in, .trdy_n_in,
    .devsel_n_in, .stop_n_in, .lock_n_in, .idsel, .ad_in, .cbe_n_in, .par_in, .perr_n_in,
    .req_n, .mst_start, .mst_last, .tgt_claim, .tgt_stop, .tgt_done, .rx_data_phase,
    .serr_enable, .parity_resp_en, .transparent_mode, .sys_err_evt, .status_clear,
    .frame_n_out, .frame_oe, .devsel_n_out, .devsel_oe, .stop_n_out, .stop_oe, .perr_n_out,
    .perr_oe, .serr_n_out, .serr_oe, .cfg_claim, .mst_abort, .mst_terminated,
    .upstream_locked, .err_status);
  pci_tgt_model u_tgt (.clk, .rstn, .frame_n(frame_n_in), .respond, .stop_req,
    .devsel_n(pd_devsel_n), .stop_n(pd_stop_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // even parity, one cycle after the phase
  always @(posedge clk) par_in <= ^{ad_in, cbe_n_in} ^ par_bad;
  always @(posedge clk) seen <= clr ? 5'h00 : seen | {mst_abort, mst_terminated, cfg_claim,
    perr_oe && !perr_n_out, serr_oe && !serr_n_out};
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_st(input err_status_t e);
    n_tests++;
    if (err_status !== e) begin
      failures++;
      $display("BAD err_status exp %h got %h", e, err_status);
    end
  endtask
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic mst(input logic resp, input logic stp);
    @(posedge clk);
    {respond, stop_req, mst_last, clr, mst_start, irdy_n_in} <= {resp, stp, !stp, 3'b110};
    @(posedge clk);
    {clr, mst_start} <= 2'b00;
    for (int i = 0; i < 20 && (i < 2 || frame_oe !== 1'b0); i++) @(posedge clk);
    {irdy_n_in, respond, stop_req} <= 3'b100;
    step(2);
    chk_bit("mst_abort", !resp, seen[4]);
    chk_bit("mst_terminated", resp && stp, seen[3]);
    chk_bit("frame_oe", 1'b0, frame_oe);
    if (!resp) exp_st.master_abort = 1'b1;
    if (resp && stp) exp_st.target_stop = 1'b1;
  endtask
  task automatic tgt(input logic [3:0] cmd, input logic ids);
    logic cfg, act;
    cfg = ids && (cmd == CMD_CFG_READ || cmd == CMD_CFG_WRITE);
    act = cfg || cmd == 4'h6;
    @(posedge clk);
    lf = lfsr(lf);
    {clr, bus_frame_n, idsel, cbe_n_in, lock_n_in} <= {2'b10, ids, ~cmd, 1'b0};
    {tgt_claim, tgt_stop} <= {cmd == 4'h6, ids};
    ad_in <= {lf, lf[15:2], 2'h0};
    @(posedge clk);
    {clr, bus_frame_n, idsel, cbe_n_in, tgt_claim} <= {2'b01, 1'b0, 4'hF, 1'b0};
    step(3);
    chk_bit("devsel_n_out", !act, devsel_n_out);
    chk_bit("stop_n_out", !(act && ids), stop_n_out);
    tgt_done <= 1'b1;
    @(posedge clk);
    tgt_done <= 1'b0;
    step(3);
    chk_bit("cfg_claim", cfg, seen[2]);
    chk_bit("devsel_oe", 1'b0, devsel_oe);
    chk_bit("upstream_locked", 1'b0, upstream_locked);
  endtask
  task automatic par(input logic bad);
    @(posedge clk);
    lf = lfsr(lf);
    {clr, rx_data_phase, par_bad, irdy_n_in, trdy_n_in} <= {2'b11, bad, 2'b00};
    ad_in <= {lf, ~lf};
    @(posedge clk);
    {clr, rx_data_phase, par_bad, irdy_n_in, trdy_n_in} <= 5'b00011;
    step(4);
    chk_bit("perr", bad, seen[1]);
    if (bad) exp_st.data_par_err = 1'b1;
  endtask
  task automatic serr(input int i, input logic en, input logic tm);
    @(posedge clk);
    {clr, serr_enable, transparent_mode} <= {1'b1, en, tm};
    @(posedge clk);
    clr <= 1'b0;
    sys_err_evt <= sys_err_t'(9'h001 << i);
    @(posedge clk);
    sys_err_evt <= sys_err_t'(9'h000);
    step(3);
    chk_bit("serr", en && (i != 0 || tm), seen[0]);
    if (i != 0 || tm) exp_st[i] = 1'b1;
  endtask
  task automatic req(input int gap);
    @(posedge clk);
    lf = lfsr(lf);
    req_n <= ~(4'h1 << lf[1:0]);
    step(2);
    req_n <= 4'hF;
    step(gap);
    req_n <= ~(4'h1 << lf[1:0]);
    step(2);
    req_n <= 4'hF;
    step(3);
    if (gap < REQ_REL_MIN_CYCLES) exp_st.req_spacing_err = 1'b1;
    chk_st(exp_st);
  endtask
  initial begin
    step(20000);
    failures++;
    conclude();
  end
  initial begin
    {rstn, irdy_n_in, lock_n_in, idsel, par_bad, mst_start, mst_last, tgt_claim} = 8'h60;
    {tgt_done, rx_data_phase, serr_enable, transparent_mode, status_clear} = 5'h00;
    {tgt_stop, parity_resp_en, bus_frame_n, respond, stop_req, clr} = 6'h3C;
    {ad_in, cbe_n_in, req_n, lf} = {32'h0000_0000, 8'hFF, 16'h0010};
    sys_err_evt = sys_err_t'(9'h000);
    trdy_n_in = 1'b1;
    exp_st = '0;
    step(2);
    rstn <= 1'b1;
    step(2);
    chk_st(exp_st);
    mst(1'b1, 1'b0);
    mst(1'b0, 1'b0);
    mst(1'b1, 1'b1);
    for (int k = 0; k < 6; k++) tgt(k % 3 == 0 ? CMD_CFG_READ : k % 3 == 1 ? CMD_CFG_WRITE
      : 4'h6, k > 2);
    par(1'b0);
    par(1'b1);
    for (int k = 0; k < 36; k++) serr(k % 9, k / 9 > 1, k / 9 % 2 == 1);
    req(2);
    req(1);
    @(posedge clk);
    status_clear <= 1'b1;
    @(posedge clk);
    status_clear <= 1'b0;
    step(2);
    exp_st = '0;
    chk_st(exp_st);
    conclude();
  end
endmodule
`default_nettype wire
